// ===== verilog/dual_timer.sv
// dual 8-bit-pair timer/counter with overflow flags and interrupt gating
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dual_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // external pins
  input wire logic timer0CountPin,
  input wire logic timer1CountPin,
  input wire logic timer0GatePin,
  input wire logic timer1GatePin,
  // processor interrupt side
  input wire logic timer0IntAck,
  input wire logic timer1IntAck,
  output logic timer0IntReq,
  output logic timer1IntReq,
  output logic timer0PriorityBit,
  output logic timer1PriorityBit,
  output logic [7:0] timer0Vector,
  output logic [7:0] timer1Vector,
  output logic [2:0] timer0NatPri,
  output logic [2:0] timer1NatPri,
  output logic irq,
  // overflow pulse for a baud-rate user
  output logic timer1OverflowPulse
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages per pin; a change counts once stages 2 and 3 agree
  logic [3:0] pinS1_r, pinS2_r, pinS3_r;
  logic [3:0] pinStable_r;
  logic [3:0] pinS1_nxt, pinS2_nxt, pinS3_nxt, pinStable_nxt;

  always_comb begin
    pinS1_nxt = {timer1GatePin, timer0GatePin, timer1CountPin, timer0CountPin};
    pinS2_nxt = pinS1_r;
    pinS3_nxt = pinS2_r;
    pinStable_nxt = pinStable_r;
    for (int i = 0; i < 4; i++) begin
      if (pinS2_r[i] == pinS3_r[i]) begin
        pinStable_nxt[i] = pinS3_r[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinS1_r <= 4'h0;
      pinS2_r <= 4'h0;
      pinS3_r <= 4'h0;
      pinStable_r <= 4'h0;
    end else begin
      pinS1_r <= pinS1_nxt;
      pinS2_r <= pinS2_nxt;
      pinS3_r <= pinS3_nxt;
      pinStable_r <= pinStable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  logic [3:0] prescale_r, prescale_nxt;
  logic [1:0] cntPinPrev_r, cntPinPrev_nxt;
  logic machineTick;
  logic [1:0] pinFall;

  always_comb begin
    prescale_nxt = (prescale_r == timer_pkg::TICK_LAST) ? 4'h0 : prescale_r + 4'h1;
    cntPinPrev_nxt = pinStable_r[1:0];
  end

  assign machineTick = (prescale_r == timer_pkg::TICK_LAST); // see R16
  assign pinFall = cntPinPrev_r & ~pinStable_r[1:0]; // see R16

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale_r <= 4'h0;
      cntPinPrev_r <= 2'h0;
    end else begin
      prescale_r <= prescale_nxt;
      cntPinPrev_r <= cntPinPrev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers and counters
  // ----------------------------------------------------------------
  logic [7:0] modeReg_r, modeReg_nxt;
  logic [7:0] ienReg_r, ienReg_nxt;
  logic [7:0] ipriReg_r, ipriReg_nxt;
  logic run0_r, run0_nxt, run1_r, run1_nxt;
  logic ovf0_r, ovf0_nxt, ovf1_r, ovf1_nxt;
  logic [7:0] low0_r, low0_nxt, high0_r, high0_nxt;
  logic [7:0] low1_r, low1_nxt, high1_r, high1_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic t1Pulse_r, t1Pulse_nxt;

  // count step for one timer in modes 0..3; returns {overflow, high, low}
  function automatic logic [16:0] stepTimer(input timer_pkg::tmode_t m,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [8:0] loSum;
    logic [8:0] hiSum;
    logic [16:0] res;
    loSum = 9'h000;
    hiSum = 9'h000;
    res = {1'b0, hi, lo};
    unique case (m)
      timer_pkg::MODE_13BIT: begin
        // upper three low-byte bits are left alone
        loSum = {4'h0, lo[4:0]} + 9'h001; // see R01
        if (lo[4:0] == timer_pkg::PRESCALE_ALL) begin
          hiSum = {1'b0, hi} + 9'h001;
        end else begin
          hiSum = {1'b0, hi};
        end
        res = {hiSum[8], hiSum[7:0], lo[7:5], loSum[4:0]}; // see R02
      end
      timer_pkg::MODE_16BIT: begin
        res = 17'({1'b0, hi, lo} + 17'h00001); // see R05
      end
      timer_pkg::MODE_RELOAD: begin
        loSum = {1'b0, lo} + 9'h001;
        if (loSum[8]) begin
          res = {1'b1, hi, hi}; // see R06
        end else begin
          res = {1'b0, hi, loSum[7:0]};
        end
      end
      timer_pkg::MODE_SPLIT: begin
        // low byte only; high byte handled by caller
        loSum = {1'b0, lo} + 9'h001; // see R07
        res = {loSum[8], hi, loSum[7:0]};
      end
    endcase
    return res;
  endfunction

  timer_pkg::tmode_t mode0, mode1;
  logic enable0, enable1, count0, count1, countHigh0;
  logic [16:0] step0, step1;
  logic [8:0] high0Sum;
  logic hitOvf0, hitOvf1;

  always_comb begin
    mode0 = timer_pkg::tmode_t'(modeReg_r[1:0]);
    mode1 = timer_pkg::tmode_t'(modeReg_r[timer_pkg::NIB1_LSB +: 2]);
    enable0 = run0_r && (!modeReg_r[timer_pkg::MODE_GATE] || pinStable_r[2]); // see R03
    enable1 = run1_r
      && (!modeReg_r[timer_pkg::NIB1_LSB + timer_pkg::MODE_GATE] || pinStable_r[3]); // see R04
    count0 = enable0
      && (modeReg_r[timer_pkg::MODE_CNT] ? pinFall[0] : machineTick); // see R16
    count1 = enable1 && (mode1 != timer_pkg::MODE_SPLIT) // see R09
      && (modeReg_r[timer_pkg::NIB1_LSB + timer_pkg::MODE_CNT] ? pinFall[1] : machineTick);
    // split high byte: internal clock only, run bit of timer 1, no gating
    countHigh0 = (mode0 == timer_pkg::MODE_SPLIT) && run1_r && machineTick; // see R08
    step0 = stepTimer(mode0, low0_r, high0_r);
    step1 = stepTimer(mode1, low1_r, high1_r);
    high0Sum = {1'b0, high0_r} + 9'h001;
    hitOvf0 = count0 && step0[16];
    // timer 1 still runs in other modes while timer 0 is split
    hitOvf1 = (count1 && step1[16]) || (countHigh0 && high0Sum[8]); // see R10
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_comb begin
    modeReg_nxt = modeReg_r;
    ienReg_nxt = ienReg_r;
    ipriReg_nxt = ipriReg_r;
    run0_nxt = run0_r;
    run1_nxt = run1_r;
    ovf0_nxt = ovf0_r;
    ovf1_nxt = ovf1_r;
    low0_nxt = low0_r;
    high0_nxt = high0_r;
    low1_nxt = low1_r;
    high1_nxt = high1_r;
    rdata_nxt = timer_pkg::REG_RESET;
    t1Pulse_nxt = hitOvf1;

    // counters advance
    if (count0) begin
      low0_nxt = step0[7:0];
      if (mode0 != timer_pkg::MODE_SPLIT) begin
        high0_nxt = step0[15:8];
      end
    end
    if (countHigh0) begin
      high0_nxt = high0Sum[7:0];
    end
    if (count1) begin
      low1_nxt = step1[7:0];
      high1_nxt = step1[15:8];
    end

    // software writes; a counter write overrides a count in the same cycle
    if (regWr) begin
      unique case (regAddr)
        timer_pkg::CTRL_ADDR: begin
          ovf1_nxt = regWdata[timer_pkg::CTRL_OVF1]; // see R13
          run1_nxt = regWdata[timer_pkg::CTRL_RUN1]; // see R18
          ovf0_nxt = regWdata[timer_pkg::CTRL_OVF0]; // see R13
          run0_nxt = regWdata[timer_pkg::CTRL_RUN0];
        end
        timer_pkg::MODE_ADDR: modeReg_nxt = regWdata; // see R17
        timer_pkg::LOW0_ADDR: low0_nxt = regWdata;
        timer_pkg::HIGH0_ADDR: high0_nxt = regWdata;
        timer_pkg::LOW1_ADDR: low1_nxt = regWdata;
        timer_pkg::HIGH1_ADDR: high1_nxt = regWdata;
        timer_pkg::IEN_ADDR: ienReg_nxt = regWdata; // see R14
        timer_pkg::IPRI_ADDR: ipriReg_nxt = regWdata & timer_pkg::IPRI_MASK; // see R15
        default: ;
      endcase
    end

    // vector entry clears the flag, but a fresh overflow wins
    if (timer0IntAck) begin
      ovf0_nxt = 1'b0; // see R11
    end
    if (timer1IntAck) begin
      ovf1_nxt = 1'b0; // see R11
    end
    if (hitOvf0) begin
      ovf0_nxt = 1'b1; // see R02
    end
    if (hitOvf1) begin
      ovf1_nxt = 1'b1; // see R02
    end

    if (regRd) begin
      unique case (regAddr)
        timer_pkg::CTRL_ADDR: begin
          rdata_nxt = {ovf1_r, run1_r, ovf0_r, run0_r, 4'h0}; // see R18
        end
        timer_pkg::MODE_ADDR: rdata_nxt = modeReg_r;
        timer_pkg::LOW0_ADDR: rdata_nxt = low0_r;
        timer_pkg::HIGH0_ADDR: rdata_nxt = high0_r;
        timer_pkg::LOW1_ADDR: rdata_nxt = low1_r;
        timer_pkg::HIGH1_ADDR: rdata_nxt = high1_r;
        timer_pkg::IEN_ADDR: rdata_nxt = ienReg_r;
        timer_pkg::IPRI_ADDR: rdata_nxt = ipriReg_r;
        default: rdata_nxt = timer_pkg::REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeReg_r <= timer_pkg::REG_RESET;
      ienReg_r <= timer_pkg::REG_RESET;
      ipriReg_r <= timer_pkg::REG_RESET;
      run0_r <= 1'b0;
      run1_r <= 1'b0;
      ovf0_r <= 1'b0;
      ovf1_r <= 1'b0;
      low0_r <= timer_pkg::REG_RESET;
      high0_r <= timer_pkg::REG_RESET;
      low1_r <= timer_pkg::REG_RESET;
      high1_r <= timer_pkg::REG_RESET;
      rdata_r <= timer_pkg::REG_RESET;
      t1Pulse_r <= 1'b0;
    end else begin
      modeReg_r <= modeReg_nxt;
      ienReg_r <= ienReg_nxt;
      ipriReg_r <= ipriReg_nxt;
      run0_r <= run0_nxt;
      run1_r <= run1_nxt;
      ovf0_r <= ovf0_nxt;
      ovf1_r <= ovf1_nxt;
      low0_r <= low0_nxt;
      high0_r <= high0_nxt;
      low1_r <= low1_nxt;
      high1_r <= high1_nxt;
      rdata_r <= rdata_nxt;
      t1Pulse_r <= t1Pulse_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  assign regRdata = rdata_r;
  assign timer0IntReq = ovf0_r && ienReg_r[timer_pkg::IEN_T0]
    && ienReg_r[timer_pkg::IEN_GLOBAL]; // see R19
  assign timer1IntReq = ovf1_r && ienReg_r[timer_pkg::IEN_T1]
    && ienReg_r[timer_pkg::IEN_GLOBAL]; // see R19
  assign irq = timer0IntReq || timer1IntReq;
  assign timer0PriorityBit = ipriReg_r[timer_pkg::IPRI_T0]; // see R15
  assign timer1PriorityBit = ipriReg_r[timer_pkg::IPRI_T1];
  assign timer0Vector = timer_pkg::VEC_T0; // see R12
  assign timer1Vector = timer_pkg::VEC_T1;
  assign timer0NatPri = timer_pkg::NATPRI_T0;
  assign timer1NatPri = timer_pkg::NATPRI_T1;
  assign timer1OverflowPulse = t1Pulse_r;

endmodule // dual_timer

`default_nettype wire

// ===== verilog/timer_pkg.sv
// constants, register map and types for the dual timer/counter block
//
// Summary of operation
// R01: mode 0 counts 13 bits: high byte plus low five bits of low byte.
// R02: rollover of all valid count bits to zero sets the timer overflow flag.
// R03: timer 0 counts while run bit set and gating off or gate pin high.
// R04: timer 1 counts while its run bit set and gating off or gate pin high.
// R05: mode 1 is mode 0 with all sixteen bits cascaded.
// R06: mode 2 low byte counts, overflow sets flag and reloads from high byte.
// R07: timer 0 mode 3 low byte is an 8-bit counter using timer 0 controls.
// R08: timer 0 mode 3 high byte times clocks, runs on timer 1 run bit, flag.
// R09: timer 1 in mode 3 holds its count as if its run bit were clear.
// R10: timer 1 keeps working in other modes while timer 0 is in mode 3.
// R11: overflow flag clears automatically when its interrupt routine is entered.
// R12: timer 0 vector 0x0B priority 2, timer 1 vector 0x1B priority 4.
// R13: software writes set or clear interrupt flags like hardware does.
// R14: enable register at 0xA8: global bit 7, timer 0 bit 1, timer 1 bit 3.
// R15: priority register at 0xB8: timer 0 bit 1, timer 1 bit 3.
// R16: timer mode counts every 12 clocks; counter mode on falling pin edge.
// R17: mode register: gate, counter select, two mode bits; timer 1 upper nibble.
// R18: control register at 0x88: bits 7..4 are flag1, run1, flag0, run0.
// R19: interrupt request only while flag, its enable and global enable are set.
package timer_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h88;
  localparam logic [7:0] LOW0_ADDR = 8'h8A;
  localparam logic [7:0] LOW1_ADDR = 8'h8B;
  localparam logic [7:0] HIGH0_ADDR = 8'h8C;
  localparam logic [7:0] HIGH1_ADDR = 8'h8D;
  localparam logic [7:0] MODE_ADDR = 8'h89;
  localparam logic [7:0] IEN_ADDR = 8'hA8;
  localparam logic [7:0] IPRI_ADDR = 8'hB8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OVF1 = 7;
  localparam int CTRL_RUN1 = 6;
  localparam int CTRL_OVF0 = 5;
  localparam int CTRL_RUN0 = 4;
  localparam int IEN_GLOBAL = 7;
  localparam int IEN_T1 = 3;
  localparam int IEN_T0 = 1;
  localparam int IPRI_T1 = 3;
  localparam int IPRI_T0 = 1;
  localparam int MODE_GATE = 3;
  localparam int MODE_CNT = 2;
  localparam int NIB1_LSB = 4;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IPRI_MASK = 8'h3F;
  localparam logic [4:0] PRESCALE_ALL = 5'h1F;
  localparam int TICK_CLOCKS = 12;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CLOCKS - 1);

  // ----------------------------------------------------------------
  // interrupt vectors and natural priorities
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_T0 = 8'h0B;
  localparam logic [7:0] VEC_T1 = 8'h1B;
  localparam logic [2:0] NATPRI_T0 = 3'h2;
  localparam logic [2:0] NATPRI_T1 = 3'h4;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } tmode_t;

endpackage

// ===== testbench/dual_timer_properties.sv
// concurrent checks on the dual timer ports
`timescale 1ns/1ps
`default_nettype none

module dual_timer_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  // interrupt side
  input wire logic timer0IntAck,
  input wire logic timer0IntReq,
  input wire logic timer1IntReq,
  input wire logic timer0PriorityBit,
  input wire logic timer1PriorityBit,
  input wire logic [7:0] timer0Vector,
  input wire logic [7:0] timer1Vector,
  input wire logic [2:0] timer0NatPri,
  input wire logic [2:0] timer1NatPri,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // shadow copies of enable and priority, rebuilt from bus writes
  logic [7:0] ieR;
  logic [7:0] ipR;
  // run bit of timer 0; while clear no overflow can race a clear
  logic run0R;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ieR <= 8'h00;
      ipR <= 8'h00;
      run0R <= 1'b0;
    end else if (regWr && regAddr == timer_pkg::CTRL_ADDR) begin
      run0R <= regWdata[timer_pkg::CTRL_RUN0];
    end else if (regWr && regAddr == timer_pkg::IEN_ADDR) begin
      ieR <= regWdata;
    end else if (regWr && regAddr == timer_pkg::IPRI_ADDR) begin
      ipR <= regWdata;
    end
  end

  a_irq_merge: assert property (irq == (timer0IntReq | timer1IntReq))
    else $error("irq differs from the two requests");
  a_mask_t0: assert property (!(ieR[7] && ieR[1]) |-> !timer0IntReq)
    else $error("timer0 request while masked");
  a_mask_t1: assert property (!(ieR[7] && ieR[3]) |-> !timer1IntReq)
    else $error("timer1 request while masked");
  a_vector_values: assert property (timer0Vector == 8'h0B && timer1Vector == 8'h1B)
    else $error("wrong vector");
  a_natural_pri: assert property (timer0NatPri == 3'h2 && timer1NatPri == 3'h4)
    else $error("wrong natural priority");
  a_pri_bits: assert property ({timer1PriorityBit, timer0PriorityBit} == {ipR[3], ipR[1]})
    else $error("priority bit differs from register");
  a_ack_clears: assert property (timer0IntAck && !run0R |=> !timer0IntReq)
    else $error("flag survived vector entry");
  a_sw_set: assert property (regWr && regAddr == timer_pkg::CTRL_ADDR && regWdata[5]
    && ieR[7] && ieR[1] |=> timer0IntReq [*2])
    else $error("software set gave no request");
  a_sw_clear: assert property (regWr && regAddr == timer_pkg::CTRL_ADDR && !regWdata[5]
    && !run0R |=> !timer0IntReq)
    else $error("software clear left request");
endmodule // dual_timer_properties

bind dual_timer dual_timer_properties CHK (.sys_clk, .rst, .regAddr, .regWdata, .regWr,
  .timer0IntAck, .timer0IntReq, .timer1IntReq, .timer0PriorityBit, .timer1PriorityBit,
  .timer0Vector, .timer1Vector, .timer0NatPri, .timer1NatPri, .irq);
`default_nettype wire

// ===== testbench/pin_source.sv
// model of the external count and gate pins
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  // clock
  input wire logic sys_clk,
  // pins
  output logic count0,
  output logic count1,
  output logic timer0_gate_pin,
  output logic timer1_gate_pin
);
  // count pins idle high so only the drop is an event
  initial begin
    count0 = 1'h1;
    count1 = 1'h1;
    timer0_gate_pin = 1'h0;
    timer1_gate_pin = 1'h0;
  end

  // long levels so the synchroniser sees each one
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count0 <= 1'h0;
      repeat (8) @(posedge sys_clk);
      count0 <= 1'h1;
      repeat (8) @(posedge sys_clk);
    end
  endtask

  task automatic set_gate(input logic v);
    @(posedge sys_clk);
    timer0_gate_pin <= v;
  endtask
endmodule // pin_source
`default_nettype wire

// ===== testbench/dual_timer_tb_top.sv
// self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none

module dual_timer_tb_top;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic ack0 = 1'h0;
  logic ack1 = 1'h0;
  logic t1Pulse;
  logic [7:0] regRdata;
  logic [7:0] rdv;
  logic timer0IntReq;
  logic timer1IntReq;
  logic count0;
  logic count1;
  logic timer0_gate_pin;
  logic timer1_gate_pin;
  int err_count = 0;
  int compares = 0;

  always #25 sys_clk = ~sys_clk;

  pin_source PINS (.sys_clk, .count0, .count1, .timer0_gate_pin, .timer1_gate_pin);

  dual_timer DUT (.sys_clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .timer0CountPin(count0), .timer1CountPin(count1), .timer0GatePin(timer0_gate_pin),
    .timer1GatePin(timer1_gate_pin), .timer0IntAck(ack0), .timer1IntAck(ack1), .timer0IntReq,
    .timer1IntReq, .timer0PriorityBit(), .timer1PriorityBit(), .timer0Vector(),
    .timer1Vector(), .timer0NatPri(), .timer1NatPri(), .irq(),
    .timer1OverflowPulse(t1Pulse));

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'h0;
    #1;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    rdv = regRdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask

  // one-cycle vector entry, then the request must be gone
  task automatic ack(input logic t1);
    @(posedge sys_clk);
    if (t1) ack1 <= 1'h1;
    else ack0 <= 1'h1;
    @(posedge sys_clk);
    ack0 <= 1'h0;
    ack1 <= 1'h0;
    #1;
    chk({7'h00, t1 ? timer1IntReq : timer0IntReq}, 8'h00);
  endtask

  task automatic wait_req(input logic t1);
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      #1;
      if ((t1 ? timer1IntReq : timer0IntReq) === 1'h1) return;
    end
    err_count++;
    test_done();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    logic [7:0] addrs [7] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'hA8, 8'hB8, 8'h90};
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
    wr(8'hB8, 8'hFF);
    rdc(8'hB8, 8'h3F);
    wr(8'hB8, 8'h00);
  endtask

  task automatic s_mode1();
    wr(8'h89, 8'h01);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'hA8, 8'h82);
    wr(8'h88, 8'h10);
    wait_req(1'h0);
    rdc(8'h88, 8'h30);
    rdc(8'h8C, 8'h00);
    // stop the timer so no fresh overflow can meet the entry
    wr(8'h88, 8'h20);
    ack(1'h0);
  endtask

  task automatic s_swflag();
    wr(8'h88, 8'h20);
    chk({7'h00, timer0IntReq}, 8'h01);
    wr(8'hA8, 8'h02);
    chk({7'h00, timer0IntReq}, 8'h00);
    wr(8'hA8, 8'h82);
    wr(8'h88, 8'h00);
    chk({7'h00, timer0IntReq}, 8'h00);
  endtask

  task automatic s_reload();
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFF);
    wr(8'hA8, 8'h88);
    wr(8'h88, 8'h40);
    wait_req(1'h1);
    chk({7'h00, t1Pulse}, 8'h01);
    @(posedge sys_clk);
    #1;
    chk({7'h00, t1Pulse}, 8'h00);
    rdc(8'h8B, 8'hF0);
    rdc(8'h8D, 8'hF0);
    ack(1'h1);
    wr(8'h89, 8'h30);
    rd(8'h8B);
    repeat (40) @(posedge sys_clk);
    rdc(8'h8B, rdv);
    wr(8'h88, 8'h00);
  endtask

  task automatic s_mode3();
    wr(8'h89, 8'h03);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'hFE);
    wr(8'hA8, 8'h8A);
    wr(8'h88, 8'h40);
    wait_req(1'h1);
    chk({7'h00, timer0IntReq}, 8'h00);
    rdc(8'h8A, 8'h00);
    wr(8'h88, 8'h00);
  endtask

  task automatic s_gate();
    wr(8'h89, 8'h08);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h10);
    wr(8'h88, 8'h10);
    repeat (40) @(posedge sys_clk);
    rdc(8'h8A, 8'hFF);
    PINS.set_gate(1'h1);
    repeat (40) @(posedge sys_clk);
    rd(8'h8A);
    // one to four ticks: prescaler wrapped once, upper bits untouched
    chk({6'h00, rdv[7:5] == 3'h7, rdv[4:0] < 5'h04}, 8'h03);
    rdc(8'h8C, 8'h11);
  endtask

  task automatic s_count();
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    PINS.pulses(5);
    repeat (10) @(posedge sys_clk);
    rdc(8'h8A, 8'h05);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    s_reset();
    s_mode1();
    s_swflag();
    s_reload();
    s_mode3();
    s_gate();
    s_count();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
endmodule // dual_timer_tb_top
`default_nettype wire
